// ===== hdl/pwrdn_pkg.sv
// Package of constants and types for the power-down and oscillator divider block.
package pwrdn_pkg;

  // ---------------------------------------------------------------------------
  // Register map (byte addresses on the register bus)
  // ---------------------------------------------------------------------------
  localparam logic [31:0] OSC_CLOCK_DIVIDER_ADDR  = 32'h01b7c124;
  localparam logic [31:0] CPU_CONTROL_STATUS_ADDR = 32'h01b7c200;
  localparam logic [31:0] PLL_CONTROL_STATUS_ADDR = 32'h01b7c100;
  localparam logic [31:0] PD_STATUS_ADDR          = 32'h01b7c204;
  localparam int          ADDR_W                  = 32;

  // ---------------------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------------------
  localparam int          OSC_EN_BIT        = 15;
  localparam int          OSC_RATIO_MSB     = 4;
  localparam logic        OSC_EN_RST        = 1'b1;
  localparam logic [4:0]  OSC_RATIO_RST     = 5'h07;
  localparam int          PD_FIELD_LSB      = 10;
  localparam int          PD_FIELD_MSB      = 15;
  localparam logic [5:0]  PD_FIELD_RST      = 6'h00;
  localparam int          GIE_BIT           = 0;
  localparam int          PLL_ENGAGE_BIT    = 0;
  localparam logic        PLL_ENGAGE_RST    = 1'b0;

  // ---------------------------------------------------------------------------
  // Power-down codes and timing
  // ---------------------------------------------------------------------------
  localparam logic [5:0]  PD_NONE           = 6'h00;
  localparam logic [5:0]  PD_LIGHT_ENABLED  = 6'h09;
  localparam logic [5:0]  PD_LIGHT_ANY      = 6'h11;
  localparam logic [5:0]  PD_PLL_OUT_STOP   = 6'h1a;
  localparam logic [5:0]  PD_PLL_IN_STOP    = 6'h1c;
  localparam int          PD_TAKE_CYCLES    = 9;
  localparam logic [3:0]  PD_DELAY_CNT      = 4'(PD_TAKE_CYCLES - 1);

  typedef enum logic [2:0] {
    ST_RUN       = 3'b000,
    ST_ARM       = 3'b001,
    ST_LIGHT     = 3'b010,
    ST_OUT_STOP  = 3'b011,
    ST_IN_STOP   = 3'b100
  } pd_state_t;

  typedef struct packed {
    logic halt_cpu;
    logic stop_pll_out;
    logic stop_pll_in;
    logic freeze_io;
  } pd_gate_t;

  typedef struct packed {
    logic resume;
    logic take_isr;
  } wake_t;

endpackage

// ===== hdl/osc_divider.sv
// Programmable divider that makes the direct oscillator clock from the reference.
`timescale 1ns/1ns
module osc_divider #(
  parameter int RATIO_W = 5
) (
  // Clock and reset
  input  wire logic               i_core_clk,
  input  wire logic               i_rst,
  // Control
  input  wire logic               i_enable,
  input  wire logic [RATIO_W-1:0] i_ratio,
  // Divided clock
  output logic                    o_div_clk
);

  logic [RATIO_W-1:0] count_reg;
  logic [RATIO_W-1:0] count_next;
  logic               clk_reg;
  logic               clk_next;
  wire  logic         wrap = (count_reg >= i_ratio);
  wire  logic [RATIO_W:0] ratio_p1 = {1'b0, i_ratio} + {{RATIO_W{1'b0}}, 1'b1};
  wire  logic         high_phase = ({1'b0, count_reg} < (ratio_p1 >> 1));

  // Ratio zero toggles the edge flop every cycle, so the output runs at half the reference rate.
  assign count_next = wrap ? '0 : count_reg + 1'b1;
  assign clk_next   = !i_enable ? 1'b0 :
                      (i_ratio == '0) ? ~clk_reg : high_phase;

  always_ff @(posedge i_core_clk) begin
    if (i_rst || !i_enable) begin
      count_reg <= '0;
      clk_reg   <= 1'b0;
    end else begin
      count_reg <= count_next;
      clk_reg   <= clk_next;
    end
  end

  assign o_div_clk = clk_reg;

endmodule // osc_divider

// ===== hdl/powerdown_clock_gating.sv
// Power-down mode logic and direct oscillator clock divider with AXI4-Lite.
//
// Summary of operation
// - Divider enable bit 15 turns the divided clock off at 0; resets to 1.
// - Ratio bits 4:0 divide by value plus one, zero by two; reset value selects divide by eight.
// - Direct oscillator clock derives from the input reference, never the PLL path.
// - Power-down select field sits in control/status bits 15 to 10.
// - Selected mode takes effect nine cycles after the field write.
// - Code zero is no power-down; undefined codes select nothing.
// - Code 001001 enters light halt, woken only by an enabled interrupt.
// - Code 010001 enters light halt, woken by any interrupt.
// - Light halt gates CPU clocks at its boundary, interrupt logic keeps running.
// - Transfer engine clock keeps running during light halt.
// - Wake by a non-enabled interrupt resumes at the halted instruction.
// - Wake by an enabled interrupt runs its service routine first.
// - Service routine runs only when global and non-maskable enables are set.
// - Code 011010 stops the PLL output, halting the chip, state kept.
// - Code 011100 stops the PLL input; after reset wait for PLL lock.
// - Both deep modes end only by device reset, never by interrupts.
// - In deep modes functional outputs freeze at their last state.
// - PLL-input stop also gates the direct oscillator clock and the reference input.
// - With the PLL bypassed, deep modes do not stop the system clocks.
// - PLL engage at zero bypasses the PLL; system clocks come from reference.
`timescale 1ns/1ns
module powerdown_clock_gating #(
  parameter int RATIO_W = 5
) (
  // Clock and reset
  input  wire logic                         i_core_clk,
  input  wire logic                         i_rst,
  // AXI4-Lite write address and data
  input  wire logic                         i_awvalid,
  output logic                              o_awready,
  input  wire logic [pwrdn_pkg::ADDR_W-1:0] i_awaddr,
  input  wire logic                         i_wvalid,
  output logic                              o_wready,
  input  wire logic [31:0]                  i_wdata,
  input  wire logic [3:0]                   i_wstrb,
  // AXI4-Lite write response
  output logic                              o_bvalid,
  input  wire logic                         i_bready,
  output logic [1:0]                        o_bresp,
  // AXI4-Lite read
  input  wire logic                         i_arvalid,
  output logic                              o_arready,
  input  wire logic [pwrdn_pkg::ADDR_W-1:0] i_araddr,
  output logic                              o_rvalid,
  input  wire logic                         i_rready,
  output logic [31:0]                       o_rdata,
  output logic [1:0]                        o_rresp,
  // Interrupt controller and PLL
  input  wire logic                         i_irq_any,
  input  wire logic                         i_irq_enabled,
  input  wire logic                         i_nonmaskable_irq_enable,
  input  wire logic                         i_pll_locked,
  // Clock gates and status
  output pwrdn_pkg::pd_gate_t               o_gate,
  output logic                              o_cpu_clk_en,
  output logic                              o_transfer_clk_en,
  output logic                              o_sys_clk_from_pll,
  output logic                              o_ref_clk_en,
  output pwrdn_pkg::wake_t                  o_wake,
  output logic                              o_direct_osc_clock_out
);
  import pwrdn_pkg::*;

  // ---------------------------------------------------------------------------
  // Registers and pin synchronisers
  // ---------------------------------------------------------------------------
  logic             osc_en_reg;
  logic [4:0]       osc_ratio_reg;
  logic [5:0]       pd_field_reg;
  logic             gie_reg;
  logic             pll_engage_reg;
  logic [3:0]       delay_reg;
  logic [5:0]       pending_reg;
  pd_state_t        state_reg;
  pd_state_t        state_next;
  pd_gate_t         gate_reg;
  wake_t            wake_reg;
  logic [1:0]       irq_any_sync;
  logic [1:0]       irq_en_sync;
  logic [1:0]       nonmaskable_irq_enable_sync;
  logic [1:0]       lock_sync;
  logic             lock_wait_reg;
  logic             deep_was_in_reg;

  // AXI handshake state
  logic             aw_held_reg;
  logic             w_held_reg;
  logic [31:0]      awaddr_reg;
  logic [31:0]      wdata_reg;
  logic [3:0]       wstrb_reg;
  logic             bvalid_reg;
  logic [1:0]       bresp_reg;
  logic             rvalid_reg;
  logic [31:0]      rdata_reg;
  logic [1:0]       rresp_reg;

  // ---------------------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------------------
  wire logic        aw_take   = i_awvalid && !aw_held_reg && !bvalid_reg;
  wire logic        w_take    = i_wvalid && !w_held_reg && !bvalid_reg;
  wire logic        aw_have   = aw_held_reg || aw_take;
  wire logic        w_have    = w_held_reg || w_take;
  wire logic        do_write  = aw_have && w_have && !bvalid_reg;
  wire logic [31:0] wr_addr   = aw_held_reg ? awaddr_reg : i_awaddr;
  wire logic [31:0] wr_data   = w_held_reg ? wdata_reg : i_wdata;
  wire logic [3:0]  wr_strb   = w_held_reg ? wstrb_reg : i_wstrb;
  wire logic        wr_osc    = do_write && (wr_addr == OSC_CLOCK_DIVIDER_ADDR);
  wire logic        wr_csr    = do_write && (wr_addr == CPU_CONTROL_STATUS_ADDR);
  wire logic        wr_pll    = do_write && (wr_addr == PLL_CONTROL_STATUS_ADDR);
  wire logic        wr_stat   = do_write && (wr_addr == PD_STATUS_ADDR);
  wire logic        wr_hit    = wr_osc || wr_csr || wr_pll || wr_stat;
  wire logic        do_read   = i_arvalid && !rvalid_reg;
  wire logic        rd_osc    = (i_araddr == OSC_CLOCK_DIVIDER_ADDR);
  wire logic        rd_csr    = (i_araddr == CPU_CONTROL_STATUS_ADDR);
  wire logic        rd_pll    = (i_araddr == PLL_CONTROL_STATUS_ADDR);
  wire logic        rd_stat   = (i_araddr == PD_STATUS_ADDR);
  wire logic        rd_hit    = rd_osc || rd_csr || rd_pll || rd_stat;

  // A whole-field write lands only when its byte lane is strobed.
  wire logic        csr_hi_wr = wr_csr && wr_strb[1];
  wire logic        csr_lo_wr = wr_csr && wr_strb[0];
  wire logic [5:0]  pd_wdata  = wr_data[PD_FIELD_MSB:PD_FIELD_LSB];

  wire logic [31:0] osc_rd = {16'h0000, osc_en_reg, 10'h000, osc_ratio_reg};
  wire logic [31:0] csr_rd = {16'h0000, pd_field_reg, 9'h000, gie_reg};
  wire logic [31:0] pll_rd = {31'h00000000, pll_engage_reg};
  wire logic [31:0] stat_rd = {24'h000000, lock_wait_reg, state_reg,
                               gate_reg};
  wire logic [31:0] rd_mux = rd_osc ? osc_rd : rd_csr ? csr_rd :
                             rd_pll ? pll_rd : rd_stat ? stat_rd : 32'h0;

  // ---------------------------------------------------------------------------
  // Mode decode and wake conditions
  // ---------------------------------------------------------------------------
  wire logic irq_any     = irq_any_sync[1];
  wire logic irq_enabled = irq_en_sync[1];
  wire logic nonmaskable_irq_enable        = nonmaskable_irq_enable_sync[1];
  wire logic light_wake  = (pending_reg == PD_LIGHT_ANY)
                           ? (irq_any || irq_enabled)
                           : irq_enabled;
  wire logic run_isr     = irq_enabled && gie_reg && nonmaskable_irq_enable;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_RUN: begin
        state_next = ST_RUN;
      end
      ST_ARM: begin
        if (delay_reg == 4'h0) begin
          case (pending_reg)
            PD_LIGHT_ENABLED: state_next = ST_LIGHT;
            PD_LIGHT_ANY:     state_next = ST_LIGHT;
            PD_PLL_OUT_STOP:  state_next = ST_OUT_STOP;
            PD_PLL_IN_STOP:   state_next = ST_IN_STOP;
            default:          state_next = ST_RUN;
          endcase
        end
      end
      ST_LIGHT: begin
        if (light_wake) begin
          state_next = ST_RUN;
        end
      end
      // Deep modes hold until the device reset below.
      ST_OUT_STOP: state_next = ST_OUT_STOP;
      ST_IN_STOP:  state_next = ST_IN_STOP;
      default:     state_next = ST_RUN;
    endcase
  end

  // Deep modes only bite while the PLL is engaged.
  wire logic deep_out = (state_reg == ST_OUT_STOP) && pll_engage_reg;
  wire logic deep_in  = (state_reg == ST_IN_STOP) && pll_engage_reg;
  wire logic light_on = (state_reg == ST_LIGHT);

  // ---------------------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    irq_any_sync <= {irq_any_sync[0], i_irq_any};
    irq_en_sync  <= {irq_en_sync[0], i_irq_enabled};
    nonmaskable_irq_enable_sync    <= {nonmaskable_irq_enable_sync[0], i_nonmaskable_irq_enable};
    lock_sync    <= {lock_sync[0], i_pll_locked};
  end

  // ---------------------------------------------------------------------------
  // Software registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      osc_en_reg     <= OSC_EN_RST;
      osc_ratio_reg  <= OSC_RATIO_RST;
      pd_field_reg   <= PD_FIELD_RST;
      gie_reg        <= 1'b0;
      pll_engage_reg <= PLL_ENGAGE_RST;
    end else begin
      if (wr_osc && wr_strb[1]) begin
        osc_en_reg <= wr_data[OSC_EN_BIT];
      end
      if (wr_osc && wr_strb[0]) begin
        osc_ratio_reg <= wr_data[OSC_RATIO_MSB:0];
      end
      if (csr_hi_wr) begin
        pd_field_reg <= pd_wdata;
      end else if (state_reg == ST_LIGHT && light_wake) begin
        pd_field_reg <= PD_NONE;
      end
      if (csr_lo_wr) begin
        gie_reg <= wr_data[GIE_BIT];
      end
      if (wr_pll && wr_strb[0]) begin
        pll_engage_reg <= wr_data[PLL_ENGAGE_BIT];
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Mode sequencer
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      state_reg   <= ST_RUN;
      delay_reg   <= 4'h0;
      pending_reg <= PD_NONE;
    end else if (csr_hi_wr && state_reg == ST_RUN) begin
      state_reg   <= ST_ARM;
      delay_reg   <= PD_DELAY_CNT;
      pending_reg <= pd_wdata;
    end else begin
      state_reg <= state_next;
      if (delay_reg != 4'h0) begin
        delay_reg <= delay_reg - 4'h1;
      end
    end
  end

  // After a reset out of the input-stop mode, hold CPU until the PLL locks.
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      lock_wait_reg <= deep_was_in_reg;
    end else if (lock_sync[1]) begin
      lock_wait_reg <= 1'b0;
    end
  end

  // Remembered across reset so that the lock wait can follow the wake.
  always_ff @(posedge i_core_clk) begin
    if (deep_in) begin
      deep_was_in_reg <= 1'b1;
    end else if (!i_rst && !lock_wait_reg) begin
      deep_was_in_reg <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // Gate outputs and wake report
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      gate_reg <= '0;
      wake_reg <= '0;
    end else begin
      gate_reg.halt_cpu     <= light_on || deep_out || deep_in;
      gate_reg.stop_pll_out <= deep_out;
      gate_reg.stop_pll_in  <= deep_in;
      gate_reg.freeze_io    <= deep_out || deep_in;
      wake_reg.resume       <= light_on && light_wake;
      wake_reg.take_isr     <= light_on && light_wake && run_isr;
    end
  end

  assign o_gate             = gate_reg;
  assign o_wake             = wake_reg;
  assign o_cpu_clk_en       = !gate_reg.halt_cpu && !lock_wait_reg;
  assign o_transfer_clk_en  = !gate_reg.stop_pll_out &&
                              !gate_reg.stop_pll_in;
  assign o_sys_clk_from_pll = pll_engage_reg;
  assign o_ref_clk_en       = !gate_reg.stop_pll_in;

  // The divider runs on the reference, so it ignores PLL-output stops.
  osc_divider #(
    .RATIO_W (RATIO_W)
  ) u_osc_divider (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_enable   (osc_en_reg && !gate_reg.stop_pll_in),
    .i_ratio    (osc_ratio_reg[RATIO_W-1:0]),
    .o_div_clk  (o_direct_osc_clock_out)
  );

  // ---------------------------------------------------------------------------
  // AXI4-Lite slave
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      awaddr_reg  <= 32'h0;
      wdata_reg   <= 32'h0;
      wstrb_reg   <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= 2'b00;
    end else begin
      if (do_write) begin
        aw_held_reg <= 1'b0;
        w_held_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= wr_hit ? 2'b00 : 2'b10;
      end else begin
        if (aw_take) begin
          aw_held_reg <= 1'b1;
          awaddr_reg  <= i_awaddr;
        end
        if (w_take) begin
          w_held_reg <= 1'b1;
          wdata_reg  <= i_wdata;
          wstrb_reg  <= i_wstrb;
        end
        if (bvalid_reg && i_bready) begin
          bvalid_reg <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0;
      rresp_reg  <= 2'b00;
    end else if (do_read) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= rd_mux;
      rresp_reg  <= rd_hit ? 2'b00 : 2'b10;
    end else if (rvalid_reg && i_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  assign o_awready = !aw_held_reg && !bvalid_reg;
  assign o_wready  = !w_held_reg && !bvalid_reg;
  assign o_bvalid  = bvalid_reg;
  assign o_bresp   = bresp_reg;
  assign o_arready = !rvalid_reg;
  assign o_rvalid  = rvalid_reg;
  assign o_rdata   = rdata_reg;
  assign o_rresp   = rresp_reg;

endmodule // powerdown_clock_gating

// ===== bench/pwrdn_props.sv
// Concurrent checks on the ports of the power-down block.
`timescale 1ns/1ns
module pwrdn_props (
  // Clock and reset
  input wire logic                i_core_clk,
  input wire logic                i_rst,
  // Gates and wake
  input wire pwrdn_pkg::pd_gate_t o_gate,
  input wire logic                o_cpu_clk_en,
  input wire logic                o_transfer_clk_en,
  input wire logic                o_sys_clk_from_pll,
  input wire pwrdn_pkg::wake_t    o_wake
);
  import pwrdn_pkg::*;

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  // ---------------------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------------------
  a_halt_gates_cpu: assert property (
    o_gate.halt_cpu |-> !o_cpu_clk_en) else $error("cpu clock runs in halt");
  a_transfer_runs: assert property (
    o_gate.halt_cpu && !o_gate.freeze_io |-> o_transfer_clk_en)
    else $error("transfer clock off");
  a_deep_needs_pll: assert property (
    (o_gate.stop_pll_out || o_gate.stop_pll_in) |-> o_sys_clk_from_pll)
    else $error("deep gate while bypassed");
  a_out_stop_held: assert property (
    o_gate.stop_pll_out |=> o_gate.stop_pll_out) else $error("out stop left");
  a_in_stop_held: assert property (
    o_gate.stop_pll_in |=> o_gate.stop_pll_in) else $error("in stop left");
  a_isr_on_wake: assert property (
    o_wake.take_isr |-> o_wake.resume) else $error("isr without resume");
  a_wake_one_pulse: assert property (
    $rose(o_wake.resume) |=> !o_wake.resume) else $error("resume too long");
  a_wake_ends_halt: assert property (
    o_wake.resume |-> ##[0:3] !o_gate.halt_cpu) else $error("halt not ended");
  a_reset_clears: assert property (
    $fell(i_rst) |-> o_gate == '0 && o_wake == '0) else $error("gates after rst");

  c_light: cover property (o_gate.halt_cpu);
  c_out_stop: cover property (o_gate.stop_pll_out);
  c_isr: cover property (o_wake.take_isr);
endmodule // pwrdn_props

// ===== bench/tb_top.sv
// Self-checking testbench of the power-down and oscillator divider block.
`timescale 1ns/1ns
module tb_top;
  import pwrdn_pkg::*;
  logic        i_core_clk, i_rst, i_awvalid, i_wvalid, i_bready;
  logic        i_arvalid, i_rready, i_irq_any, i_irq_enabled;
  logic        i_nonmaskable_irq_enable, i_pll_locked;
  logic [31:0] i_awaddr, i_wdata, i_araddr, o_rdata;
  logic [3:0]  i_wstrb;
  logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  logic [1:0]  o_bresp, o_rresp;
  pd_gate_t    o_gate;
  wake_t       o_wake;
  logic        o_cpu_clk_en, o_transfer_clk_en, o_sys_clk_from_pll;
  logic        o_ref_clk_en, o_direct_osc_clock_out;
  int          bad_count, n_checks, cyc;
  logic [31:0] d;
  logic [1:0]  r;

  powerdown_clock_gating i_powerdown_clock_gating (.*);

  initial i_core_clk = 1'b0;
  always #2 i_core_clk = ~i_core_clk;

  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  always @(posedge i_core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      $display("FAIL run_length expected done seen timeout");
      test_done;
    end
  end

  task automatic chk(input string nm, input logic [31:0] exp, got);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge i_core_clk);
  endtask

  task automatic do_reset;
    @(posedge i_core_clk);
    i_rst <= 1'b1;
    tick(3);
    i_rst <= 1'b0;
  endtask

  // Address and data go out together; each is dropped once taken.
  task automatic wr(input logic [31:0] a, dat);
    logic ad, wd;
    ad = 0;
    wd = 0;
    @(posedge i_core_clk);
    i_awaddr <= a;
    i_wdata <= dat;
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    i_bready <= 1'b1;
    forever begin
      @(posedge i_core_clk);
      if (o_bvalid && ad && wd) begin
        r = o_bresp;
        i_bready <= 1'b0;
        break;
      end
      if (i_awvalid && o_awready) begin
        ad = 1;
        i_awvalid <= 1'b0;
      end
      if (i_wvalid && o_wready) begin
        wd = 1;
        i_wvalid <= 1'b0;
      end
    end
  endtask

  task automatic rd(input logic [31:0] a);
    @(posedge i_core_clk);
    i_araddr <= a;
    i_arvalid <= 1'b1;
    i_rready <= 1'b1;
    forever begin
      @(posedge i_core_clk);
      if (o_rvalid && !i_arvalid) begin
        d = o_rdata;
        r = o_rresp;
        i_rready <= 1'b0;
        break;
      end
      if (i_arvalid && o_arready) i_arvalid <= 1'b0;
    end
  endtask

  task automatic count_hi(output int h);
    h = 0;
    repeat (8) begin
      @(posedge i_core_clk);
      h += int'(o_direct_osc_clock_out === 1'b1);
    end
  endtask

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic t_reset;
    rd(OSC_CLOCK_DIVIDER_ADDR);
    chk("osc_reg", 32'h00008007, d);
    rd(PLL_CONTROL_STATUS_ADDR);
    chk("engage", 32'h0, d & 32'h1);
    rd(CPU_CONTROL_STATUS_ADDR);
    chk("pd_field", 32'h0, d & 32'h0000fc00);
    rd(32'h01b7c300);
    chk("unmapped", 32'h2, {30'h0, r});
    wr(32'h01b7c300, 32'h0);
    chk("wr_unmapped", 32'h2, {30'h0, r});
    $display("test reset done");
  endtask

  task automatic t_divider;
    logic p;
    int h;
    wr(OSC_CLOCK_DIVIDER_ADDR, 32'h00008000);
    tick(3);
    repeat (4) begin
      p = o_direct_osc_clock_out;
      @(posedge i_core_clk);
      chk("div1_toggle", {31'h0, ~p}, {31'h0, o_direct_osc_clock_out});
    end
    wr(OSC_CLOCK_DIVIDER_ADDR, 32'h00008003);
    tick(4);
    count_hi(h);
    chk("div4_high", 32'd4, 32'(h));
    wr(OSC_CLOCK_DIVIDER_ADDR, 32'h00000003);
    tick(3);
    count_hi(h);
    chk("div_off_high", 32'd0, 32'(h));
    $display("test divider done");
  endtask

  task automatic t_light(input logic [5:0] code, input logic global_irq_enable, nonmaskable_irq_enable);
    int n;
    n = 0;
    i_nonmaskable_irq_enable <= nonmaskable_irq_enable;
    wr(CPU_CONTROL_STATUS_ADDR, {16'h0, code, 9'h0, global_irq_enable});
    while (o_cpu_clk_en === 1'b1) begin
      @(posedge i_core_clk);
      n++;
    end
    chk("entry_in_time", 32'h1, {31'h0, n <= 10});
    chk("halt_cpu", 32'h1, {31'h0, o_gate.halt_cpu});
    chk("transfer_run", 32'h1, {31'h0, o_transfer_clk_en});
    if (code == PD_LIGHT_ENABLED) begin
      i_irq_any <= 1'b1;
      tick(6);
      chk("halt_kept", 32'h1, {31'h0, o_gate.halt_cpu});
    end
    i_irq_any <= 1'b1;
    i_irq_enabled <= (code == PD_LIGHT_ENABLED);
    while (o_wake.resume !== 1'b1) @(posedge i_core_clk);
    chk("take_isr", {31'h0, global_irq_enable & nonmaskable_irq_enable}, {31'h0, o_wake.take_isr});
    i_irq_any <= 1'b0;
    i_irq_enabled <= 1'b0;
    tick(3);
    chk("cpu_resumed", 32'h1, {31'h0, o_cpu_clk_en});
    $display("test light %h done", code);
  endtask

  task automatic t_reserved;
    wr(CPU_CONTROL_STATUS_ADDR, 32'h00001400);
    tick(14);
    chk("reserved_gate", 32'h0, {28'h0, o_gate});
    chk("reserved_cpu", 32'h1, {31'h0, o_cpu_clk_en});
    $display("test reserved done");
  endtask

  task automatic t_deep(input logic [5:0] code, input logic eng);
    pd_gate_t g;
    logic in_stop;
    int h;
    in_stop = (code == PD_PLL_IN_STOP);
    do_reset;
    wr(PLL_CONTROL_STATUS_ADDR, {31'h0, eng});
    chk("sys_from_pll", {31'h0, eng}, {31'h0, o_sys_clk_from_pll});
    wr(CPU_CONTROL_STATUS_ADDR, {16'h0, code, 10'h0});
    tick(12);
    g = o_gate;
    chk("deep_gate", eng ? {29'h0, !in_stop, in_stop, 1'b0} : 32'h0,
        {28'h0, g[3:2], g[1:0]} & 32'h6);
    chk("freeze_io", {31'h0, eng}, {31'h0, g.freeze_io});
    chk("ref_clk_en", {31'h0, !(in_stop && eng)}, {31'h0, o_ref_clk_en});
    chk("transfer_deep", {31'h0, !eng}, {31'h0, o_transfer_clk_en});
    count_hi(h);
    chk("osc_in_deep", (in_stop && eng) ? 32'd0 : 32'd4, 32'(h));
    i_irq_any <= 1'b1;
    i_irq_enabled <= 1'b1;
    tick(8);
    chk("deep_kept", {28'h0, g}, {28'h0, o_gate});
    i_irq_any <= 1'b0;
    i_irq_enabled <= 1'b0;
    i_pll_locked <= 1'b0;
    do_reset;
    chk("gate_cleared", 32'h0, {28'h0, o_gate});
    tick(4);
    if (in_stop && eng)
      chk("lock_wait", 32'h0, {31'h0, o_cpu_clk_en});
    i_pll_locked <= 1'b1;
    tick(5);
    chk("cpu_after_rst", 32'h1, {31'h0, o_cpu_clk_en});
    $display("test deep %h done", code);
  endtask

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    {i_rst, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = 6'h21;
    {i_irq_any, i_irq_enabled, i_nonmaskable_irq_enable} = 3'h0;
    i_pll_locked = 1'b1;
    {i_awaddr, i_wdata, i_araddr} = '0;
    i_wstrb = 4'hf;
    do_reset;
    t_reset;
    t_divider;
    t_light(PD_LIGHT_ENABLED, 1'b1, 1'b1);
    t_light(PD_LIGHT_ANY, 1'b0, 1'b1);
    t_light(PD_LIGHT_ENABLED, 1'b1, 1'b0);
    t_reserved;
    t_deep(PD_PLL_OUT_STOP, 1'b1);
    t_deep(PD_PLL_IN_STOP, 1'b1);
    t_deep(PD_PLL_OUT_STOP, 1'b0);
    test_done;
  end
endmodule // tb_top

bind powerdown_clock_gating pwrdn_props i_pwrdn_props (.*);
